// >>> shared/bmsu_consts.svh
// constants for the decimal arithmetic unit
//
// Functional notes
// - condition false: results and flags untouched, sequencer moves on
// - two-word subtract: minuend minus subtrahend minus carry into two words
// - negative subtract result sets carry and stores ten's complement
// - subtract carry on exactly when the result went negative
// - subtract faults when any of its four words is not decimal
// - any operation faults on a bad or out-of-area indirect pointer
// - zero flag set when the result is zero, cleared otherwise
// - single multiply: two 4-digit words give an 8-digit two-word product
// - multiplies always clear carry, as the product fits its result words
// - double multiply: two 8-digit operands give a four-word product
// - multiplies fault on any non-decimal operand digit
// - single divide: quotient in first word, remainder in next
// - single divide faults when dividend or divisor is not decimal
// - double divide: quotient in first two words, remainder in next two
// - double divide faults when both divisor words are zero, floating divide when the divisor mantissa is zero
// - double divide faults on any non-decimal operand digit, floating divide on any non-decimal mantissa digit
// - floating divide: two-word float over two-word float gives float
// - float: low seven digits mantissa below one, top digit exponent
// - floating divide faults when quotient leaves the representable range
`ifndef BMSU_CONSTS_SVH
`define BMSU_CONSTS_SVH

// decimal scale factors
`define BMSU_TEN_E4     54'h2710
`define BMSU_TEN_E8     54'h5f5e100
`define BMSU_SUB_WRAP   28'h5f5e100

// iteration counts
`define BMSU_CONV_LAST  6'h35
`define BMSU_DIV_LAST   6'h35

// data memory area boundary
`define BMSU_DMEM_LAST  16'h1999

// floating exponent limits
`define BMSU_EXP_MAX    7'sh07
`define BMSU_EXP_MIN    7'sh79
`define BMSU_DROP_MAX   7'sh06

// result write masks
`define BMSU_WR_NONE    4'h0
`define BMSU_WR_TWO     4'h3
`define BMSU_WR_FOUR    4'hf

// reset values
`define BMSU_FLAG_RST   1'b0
`define BMSU_WORD_RST   64'h0

`endif

// >>> shared/bmsu_pkg.sv
// types for the decimal arithmetic unit
package bmsu_pkg;

    typedef enum logic [2:0] {
        op_dsub   = 3'h0,
        op_prod1  = 3'h1,
        op_prod2  = 3'h2,
        op_quot1  = 3'h3,
        op_quot2  = 3'h4,
        op_fquot  = 3'h5
    } bmsu_op_type;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_divw = 2'h1,
        st_conv = 2'h2,
        st_fin  = 2'h3
    } bmsu_state_type;

endpackage

// >>> shared/bmsu_div_if.sv
// divide request and answer between the unit and its divider
`timescale 1ns/1ps

interface bmsu_div_if;
    logic        start;
    logic [53:0] dividend;
    logic [26:0] divisor;
    logic        busy;
    logic        done;
    logic [53:0] quotient;
    logic [26:0] remainder;

    modport ctrl (output start, dividend, divisor,
                  input  busy, done, quotient, remainder);
    modport core (input  start, dividend, divisor,
                  output busy, done, quotient, remainder);
endinterface

// >>> src/bmsu_divcore.sv
// restoring binary divider, one quotient bit per clock
`timescale 1ns/1ps
`include "bmsu_consts.svh"

module bmsu_divcore (
    // clock and reset
    input  wire logic  core_clk_i,
    input  wire logic  sys_rst_i,
    // divide request and answer
    bmsu_div_if.core   dv
);
    logic [27:0] part;
    logic [53:0] quo;
    logic [26:0] dvs;
    logic [5:0]  step;
    logic [27:0] shifted;
    logic [27:0] trial;

    assign shifted      = {part[26:0], quo[53]};
    assign trial        = shifted - {1'b0, dvs};
    assign dv.quotient  = quo;
    assign dv.remainder = part[26:0];

    // =========================================================
    // iteration
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            dv.busy <= 1'b0;
            dv.done <= 1'b0;
            step    <= 6'h0;
            part    <= 28'h0;
            quo     <= 54'h0;
            dvs     <= 27'h0;
        end else begin
            dv.done <= 1'b0;
            if (dv.start && !dv.busy) begin
                dv.busy <= 1'b1;
                step    <= 6'h0;
                part    <= 28'h0;
                quo     <= dv.dividend;
                dvs     <= dv.divisor;
            end else if (dv.busy) begin
                // a borrow keeps the shifted partial remainder
                part <= trial[27] ? shifted : trial;
                quo  <= {quo[52:0], ~trial[27]};
                step <= step + 6'h1;
                if (step == `BMSU_DIV_LAST) begin
                    dv.busy <= 1'b0;
                    dv.done <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> src/bmsu_top.sv
// decimal subtract, multiply, divide and floating divide execution unit
`timescale 1ns/1ps
`include "bmsu_consts.svh"

module bmsu_top
    import bmsu_pkg::*;
(
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         sys_rst_i,
    // operation request from the sequencer
    input  wire logic         op_valid_i,
    input  wire bmsu_op_type  op_code_i,
    input  wire logic         exec_cond_i,
    input  wire logic [31:0]  opnd_a_i,
    input  wire logic [31:0]  opnd_b_i,
    output      logic         ready_o,
    // indirect pointers used by the operands
    input  wire logic [2:0]   ptr_used_i,
    input  wire logic [47:0]  ptr_addr_i,
    // direct carry load
    input  wire logic         carry_load_i,
    input  wire logic         carry_value_i,
    // completion and result words
    output      logic         done_o,
    output      logic         executed_o,
    output      logic [3:0]   result_wr_o,
    output      logic [63:0]  result_o,
    // flag register
    output      logic         carry_flag_o,
    output      logic         fault_flag_o,
    output      logic         zero_flag_o
);

    // =========================================================
    // decoding helpers

    function automatic logic is_bcd(input logic [31:0] w);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (w[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [26:0] bcd_to_bin(input logic [31:0] w);
        logic [26:0] acc;
        acc = 27'h0;
        for (int i = 7; i >= 0; i--) begin
            acc = 27'(acc * 27'ha + 27'(w[4*i +: 4]));
        end
        return acc;
    endfunction

    function automatic logic signed [6:0] exp_of(input logic [3:0] d);
        logic signed [6:0] e;
        e = $signed({4'h0, d[2:0]});
        if (d[3]) begin
            e = -e;
        end
        return e;
    endfunction

    function automatic logic [3:0] lead_digit(input logic [63:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[4*i +: 4] != 4'h0) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction

    // =========================================================
    // state

    bmsu_state_type    state;
    bmsu_op_type       cur_op;
    logic              take;
    logic              run_ok;
    logic              div_op;
    logic [31:0]       chk_a;
    logic [31:0]       chk_b;
    logic [26:0]       bin_a;
    logic [26:0]       bin_b;
    logic              ptr_bad;
    logic              zero_div;
    logic              fault_now;
    logic [27:0]       sub_diff;
    logic              sub_neg;
    logic [53:0]       load_val;
    logic [53:0]       join_val;
    logic              sub_neg_q;
    logic signed [6:0] exp_sum;
    logic [53:0]       conv_bin;
    logic [63:0]       conv_bcd;
    logic [63:0]       bcd_adj;
    logic [5:0]        conv_cnt;
    logic              val_zero;

    bmsu_div_if dv ();

    bmsu_divcore u_divcore (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .dv         (dv.core)
    );

    // a request is only seen while idle; the sequencer holds it otherwise
    assign ready_o = (state == st_idle);
    assign take    = op_valid_i && ready_o;
    assign div_op  = (op_code_i == op_quot1) || (op_code_i == op_quot2)
                     || (op_code_i == op_fquot);
    assign run_ok  = take && exec_cond_i && !fault_now;

    // =========================================================
    // operand checks

    always_comb begin
        case (op_code_i)
            op_prod1, op_quot1: begin
                chk_a = {16'h0, opnd_a_i[15:0]};
                chk_b = {16'h0, opnd_b_i[15:0]};
            end
            op_fquot: begin
                // exponent digit carries the sign, so only the mantissa is decimal
                chk_a = {4'h0, opnd_a_i[27:0]};
                chk_b = {4'h0, opnd_b_i[27:0]};
            end
            default: begin
                chk_a = opnd_a_i;
                chk_b = opnd_b_i;
            end
        endcase
    end

    assign bin_a = bcd_to_bin(chk_a);
    assign bin_b = bcd_to_bin(chk_b);

    always_comb begin
        case (op_code_i)
            op_quot1: zero_div = (opnd_b_i[15:0] == 16'h0);
            op_quot2: zero_div = (opnd_b_i == 32'h0);
            op_fquot: zero_div = (opnd_b_i[27:0] == 28'h0);
            default:  zero_div = 1'b0;
        endcase
    end

    always_comb begin
        ptr_bad = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (ptr_used_i[i] && (!is_bcd({16'h0, ptr_addr_i[16*i +: 16]})
                    || ptr_addr_i[16*i +: 16] > `BMSU_DMEM_LAST)) begin
                ptr_bad = 1'b1;
            end
        end
    end

    assign fault_now = ptr_bad || !is_bcd(chk_a) || !is_bcd(chk_b) || zero_div;

    // =========================================================
    // operand arithmetic

    // borrow in bit 27 marks a negative difference
    assign sub_diff = 28'(bin_a) - 28'(bin_b) - 28'(carry_flag_o);
    assign sub_neg  = sub_diff[27];

    always_comb begin
        case (op_code_i)
            op_dsub: begin
                // ten's complement by wrapping at 10^8
                load_val = sub_neg ? 54'(28'(sub_diff + `BMSU_SUB_WRAP))
                                   : 54'(sub_diff);
            end
            default: load_val = 54'(bin_a) * 54'(bin_b);
        endcase
    end

    // floating mantissa is pre-scaled so the quotient keeps eight digits
    assign dv.start    = run_ok && div_op;
    assign dv.dividend = (op_code_i == op_fquot) ? 54'(54'(bin_a) * `BMSU_TEN_E8)
                                                 : 54'(bin_a);
    assign dv.divisor  = bin_b;

    // quotient and remainder share one conversion
    always_comb begin
        case (cur_op)
            op_quot1: join_val = 54'(dv.quotient * `BMSU_TEN_E4)
                                 + 54'(dv.remainder);
            op_quot2: join_val = 54'(dv.quotient * `BMSU_TEN_E8)
                                 + 54'(dv.remainder);
            default:  join_val = dv.quotient;
        endcase
    end

    // =========================================================
    // sequencing

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (run_ok) begin
                        state <= div_op ? st_divw : st_conv;
                    end
                end
                st_divw: begin
                    if (dv.done) begin
                        state <= st_conv;
                    end
                end
                st_conv: begin
                    if (conv_cnt == `BMSU_CONV_LAST) begin
                        state <= st_fin;
                    end
                end
                st_fin:  state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cur_op    <= op_dsub;
            sub_neg_q <= 1'b0;
            exp_sum   <= 7'sh00;
        end else if (take) begin
            cur_op    <= op_code_i;
            sub_neg_q <= sub_neg;
            exp_sum   <= exp_of(opnd_a_i[31:28]) - exp_of(opnd_b_i[31:28]);
        end
    end

    // =========================================================
    // binary to decimal conversion, one bit per clock

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_adj
            assign bcd_adj[4*g +: 4] = (conv_bcd[4*g +: 4] > 4'h4)
                                       ? 4'(conv_bcd[4*g +: 4] + 4'h3)
                                       : conv_bcd[4*g +: 4];
        end
    endgenerate

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            conv_bin <= 54'h0;
            conv_bcd <= `BMSU_WORD_RST;
            conv_cnt <= 6'h0;
            val_zero <= 1'b0;
        end else if (state == st_idle && run_ok && !div_op) begin
            conv_bin <= load_val;
            conv_bcd <= `BMSU_WORD_RST;
            conv_cnt <= 6'h0;
            val_zero <= (load_val == 54'h0);
        end else if (state == st_divw && dv.done) begin
            conv_bin <= join_val;
            conv_bcd <= `BMSU_WORD_RST;
            conv_cnt <= 6'h0;
            val_zero <= (join_val == 54'h0);
        end else if (state == st_conv) begin
            conv_bcd <= {bcd_adj[62:0], conv_bin[53]};
            conv_bin <= {conv_bin[52:0], 1'b0};
            conv_cnt <= conv_cnt + 6'h1;
        end
    end

    // =========================================================
    // floating normalisation

    logic [3:0]        f_lead;
    logic [63:0]       f_norm;
    logic [27:0]       f_mant;
    logic signed [6:0] f_exp;
    logic signed [6:0] f_drop;
    logic              f_bad;
    logic [3:0]        f_dig;

    always_comb begin
        f_lead = lead_digit(conv_bcd);
        f_norm = conv_bcd << {~f_lead, 2'b00};
        f_mant = f_norm[63:36];
        f_exp  = $signed({3'h0, f_lead}) - `BMSU_EXP_MAX + exp_sum;
        f_drop = `BMSU_EXP_MIN - f_exp;
        f_bad  = 1'b0;
        f_dig  = 4'h0;
        if (val_zero) begin
            f_mant = 28'h0;
        end else if (f_exp > `BMSU_EXP_MAX) begin
            f_bad = 1'b1;
        end else if (f_exp < `BMSU_EXP_MIN) begin
            // denormalise down to the smallest exponent before giving up
            if (f_drop > `BMSU_DROP_MAX) begin
                f_bad = 1'b1;
            end else begin
                f_mant = f_mant >> {f_drop[2:0], 2'b00};
                f_bad  = (f_mant == 28'h0);
            end
            f_dig = 4'hf;
        end else if (f_exp < 7'sh00) begin
            f_dig = {1'b1, 3'(-f_exp)};
        end else begin
            f_dig = {1'b0, f_exp[2:0]};
        end
    end

    // =========================================================
    // results, written only on the finishing edge

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            result_o    <= `BMSU_WORD_RST;
            result_wr_o <= `BMSU_WR_NONE;
        end else if (state == st_fin) begin
            case (cur_op)
                op_dsub, op_prod1: begin
                    result_o[31:0] <= conv_bcd[31:0];
                    result_wr_o    <= `BMSU_WR_TWO;
                end
                op_prod2: begin
                    result_o    <= conv_bcd;
                    result_wr_o <= `BMSU_WR_FOUR;
                end
                op_quot1: begin
                    result_o[15:0]  <= conv_bcd[31:16];
                    result_o[31:16] <= conv_bcd[15:0];
                    result_wr_o     <= `BMSU_WR_TWO;
                end
                op_quot2: begin
                    result_o[31:0]  <= conv_bcd[63:32];
                    result_o[63:32] <= conv_bcd[31:0];
                    result_wr_o     <= `BMSU_WR_FOUR;
                end
                op_fquot: begin
                    if (!f_bad) begin
                        result_o[31:0] <= {f_dig, f_mant};
                    end
                    result_wr_o <= f_bad ? `BMSU_WR_NONE : `BMSU_WR_TWO;
                end
                default: result_wr_o <= `BMSU_WR_NONE;
            endcase
        end
    end

    // =========================================================
    // flag register

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            carry_flag_o <= `BMSU_FLAG_RST;
        end else if (state == st_fin) begin
            case (cur_op)
                op_dsub:           carry_flag_o <= sub_neg_q;
                // a product always fits its result words, so no carry
                op_prod1, op_prod2: carry_flag_o <= 1'b0;
                default:           carry_flag_o <= carry_flag_o;
            endcase
        end else if (carry_load_i) begin
            carry_flag_o <= carry_value_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            fault_flag_o <= `BMSU_FLAG_RST;
        end else if (take && exec_cond_i) begin
            fault_flag_o <= fault_now;
        end else if (state == st_fin && cur_op == op_fquot) begin
            fault_flag_o <= f_bad;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            zero_flag_o <= `BMSU_FLAG_RST;
        end else if (state == st_fin && !(cur_op == op_fquot && f_bad)) begin
            zero_flag_o <= val_zero;
        end
    end

    // =========================================================
    // completion

    // skipped requests and those faulted at issue finish at once and touch nothing but the fault flag; a floating range fault runs the whole divide first
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            done_o     <= 1'b0;
            executed_o <= 1'b0;
        end else if (take && !run_ok) begin
            done_o     <= 1'b1;
            executed_o <= exec_cond_i;
        end else if (state == st_fin) begin
            done_o     <= 1'b1;
            executed_o <= 1'b1;
        end else begin
            done_o     <= 1'b0;
            executed_o <= 1'b0;
        end
    end

endmodule

// >>> tb/bmsu_chk.sv
// concurrent checks on the ports of the decimal arithmetic unit
`timescale 1ns/1ps

module bmsu_chk
    import bmsu_pkg::*;
(
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    // request side
    input wire logic        op_valid_i,
    input wire bmsu_op_type op_code_i,
    input wire logic        exec_cond_i,
    input wire logic [31:0] opnd_b_i,
    input wire logic        ready_o,
    input wire logic [2:0]  ptr_used_i,
    input wire logic [47:0] ptr_addr_i,
    // answer side
    input wire logic        done_o,
    input wire logic        executed_o,
    input wire logic [3:0]  result_wr_o,
    input wire logic [63:0] result_o,
    input wire logic        carry_flag_o,
    input wire logic        fault_flag_o,
    input wire logic        zero_flag_o
);
    logic [63:0] wmask;
    bmsu_op_type took_op;

    assign wmask = {{16{result_wr_o[3]}}, {16{result_wr_o[2]}},
                    {16{result_wr_o[1]}}, {16{result_wr_o[0]}}};

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            took_op <= op_dsub;
        end else if (op_valid_i && ready_o) begin
            took_op <= op_code_i;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_take;
        op_valid_i && ready_o;
    endsequence
    sequence s_run;
        s_take ##0 exec_cond_i;
    endsequence
    sequence s_fault_done;
        done_o && fault_flag_o;
    endsequence

    property p_skip;
        s_take ##0 !exec_cond_i |=> done_o && !executed_o && $stable(result_o)
            && $stable(fault_flag_o) && $stable(zero_flag_o);
    endproperty
    a_skip: assert property (p_skip) else $error("skipped op changed state");
    property p_only_done;
        !$stable(result_o) |-> done_o;
    endproperty
    a_only_done: assert property (p_only_done) else $error("result moved off done");
    property p_bound;
        s_take |-> ##[1:111] done_o;
    endproperty
    a_bound: assert property (p_bound) else $error("no completion in time");
    property p_zero;
        done_o && executed_o && !fault_flag_o |-> zero_flag_o == ((result_o & wmask) == 64'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_prod_cy;
        done_o && executed_o && !fault_flag_o && (took_op == op_prod1 || took_op == op_prod2)
            |-> !carry_flag_o;
    endproperty
    a_prod_cy: assert property (p_prod_cy) else $error("product carry wrong");
    property p_ptr;
        s_run ##0 ptr_used_i[0] && ptr_addr_i[15:0] > 16'h1999 |=> s_fault_done;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer fault missed");
    property p_divzero;
        s_run ##0 op_code_i == op_fquot && opnd_b_i == 32'h0 |=> s_fault_done;
    endproperty
    a_divzero: assert property (p_divzero) else $error("zero divisor missed");
    property p_nonbcd;
        s_run ##0 op_code_i == op_dsub && opnd_b_i[3:0] > 4'h9 |=> s_fault_done;
    endproperty
    a_nonbcd: assert property (p_nonbcd) else $error("bad digit missed");
    property p_fault_keep;
        s_fault_done |-> $stable(result_o);
    endproperty
    a_fault_keep: assert property (p_fault_keep) else $error("faulted op wrote");
endmodule

bind bmsu_top bmsu_chk u_chk (.core_clk_i, .sys_rst_i, .op_valid_i, .op_code_i,
    .exec_cond_i, .opnd_b_i, .ready_o, .ptr_used_i, .ptr_addr_i, .done_o, .executed_o,
    .result_wr_o, .result_o, .carry_flag_o, .fault_flag_o, .zero_flag_o);

// >>> tb/bmsu_seq_model.sv
// sequencer model: holds one request until the unit takes it
`timescale 1ns/1ps

module bmsu_seq_model (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    // command from the bench
    input  wire logic        go_i,
    input  wire logic [84:0] cmd_i,
    input  wire logic        ready_i,
    // request toward the unit
    output      logic        op_valid_o,
    output      logic [2:0]  op_code_o,
    output      logic        exec_cond_o,
    output      logic [31:0] opnd_a_o,
    output      logic [31:0] opnd_b_o,
    output      logic        ptr_used_o,
    output      logic [15:0] ptr_addr_o
);
    // pairs travel as one word, so both halves share a data area
    // a zero divisor is only sent when the bench asks for it
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            op_valid_o <= 1'b0;
        end else if (go_i) begin
            op_valid_o <= 1'b1;
            {op_code_o, exec_cond_o, opnd_a_o, opnd_b_o, ptr_used_o, ptr_addr_o} <= cmd_i;
        end else if (op_valid_o && ready_i) begin
            op_valid_o <= 1'b0;
        end
    end
endmodule

// >>> tb/test_bcd_muldiv_subtract_unit.sv
// self-checking bench for the decimal arithmetic unit
`timescale 1ns/1ps

module test_bcd_muldiv_subtract_unit
    import bmsu_pkg::*;
;
    typedef struct packed {
        bmsu_op_type op;
        logic        cond;
        logic [31:0] a;
        logic [31:0] b;
        logic [16:0] ptr;
        logic [63:0] res;
        logic [3:0]  wr;
        logic [2:0]  flg;
    } bmsu_row_type;

    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic go = 1'b0;
    logic carry_load_i = 1'b0;
    logic carry_value_i = 1'b0;
    logic op_valid_i, exec_cond_i, pu, ready_o, done_o, executed_o;
    logic carry_flag_o, fault_flag_o, zero_flag_o;
    logic [2:0] oc;
    logic [31:0] opnd_a_i, opnd_b_i;
    logic [15:0] pa;
    logic [3:0] result_wr_o;
    logic [63:0] result_o;
    bmsu_row_type cmd = '0;
    int error_cnt = 0;
    int samples_checked = 0;
    // flags column is {carry, fault, zero}; floats are {exponent digit, 7 mantissa digits}
    bmsu_row_type rows [19] = '{
        '{op_dsub, 1'b1, 32'h1029, 32'h3452, 17'h0, 64'h99997577, 4'h3, 3'h4},
        '{op_dsub, 1'b1, 32'h12345678, 32'h1, 17'h0, 64'h12345676, 4'h3, 3'h0},
        '{op_dsub, 1'b1, 32'h5, 32'h5, 17'h0, 64'h0, 4'h3, 3'h1},
        '{op_prod1, 1'b1, 32'h3, 32'h4, 17'h0, 64'h12, 4'h3, 3'h0},
        '{op_prod2, 1'b1, 32'h99999999, 32'h99999999, 17'h0, 64'h9999999800000001,
          4'hf, 3'h0},
        '{op_quot1, 1'b1, 32'h100, 32'h7, 17'h0, 64'h20014, 4'h3, 3'h0},
        '{op_quot2, 1'b1, 32'h12345678, 32'h1000, 17'h0, 64'h67800012345, 4'hf, 3'h0},
        '{op_fquot, 1'b1, 32'h15000000, 32'h12000000, 17'h0, 64'h12500000, 4'h3, 3'h0},
        '{op_fquot, 1'b1, 32'hf1000000, 32'h15000000, 17'h0, 64'hf0200000, 4'h3, 3'h0},
        '{op_dsub, 1'b1, 32'h1, 32'ha, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_prod1, 1'b0, 32'h3, 32'h4, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_prod1, 1'b1, 32'h3, 32'ha, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_quot1, 1'b1, 32'h100, 32'ha0, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_quot2, 1'b1, 32'h1234567f, 32'h1, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_fquot, 1'b1, 32'h15000000, 32'h0, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_fquot, 1'b1, 32'h75000000, 32'hf1000000, 17'h0, 64'h0, 4'h0, 3'h2},
        '{op_dsub, 1'b1, 32'h3, 32'h1, 17'h11999, 64'h2, 4'h3, 3'h0},
        '{op_dsub, 1'b1, 32'h3, 32'h1, 17'h11a00, 64'h0, 4'h0, 3'h2},
        '{op_dsub, 1'b1, 32'h0, 32'h1, 17'h0, 64'h99999999, 4'h3, 3'h4}
    };

    always #5 core_clk_i = ~core_clk_i;

    bmsu_seq_model u_seq (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .go_i(go),
        .cmd_i(cmd[155:71]), .ready_i(ready_o), .op_valid_o(op_valid_i), .op_code_o(oc),
        .exec_cond_o(exec_cond_i), .opnd_a_o(opnd_a_i), .opnd_b_o(opnd_b_i),
        .ptr_used_o(pu), .ptr_addr_o(pa));

    bmsu_top u_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .op_valid_i(op_valid_i),
        .op_code_i(bmsu_op_type'(oc)), .exec_cond_i(exec_cond_i), .opnd_a_i(opnd_a_i),
        .opnd_b_i(opnd_b_i), .ready_o(ready_o), .ptr_used_i({2'b00, pu}),
        .ptr_addr_i({32'h0, pa}), .carry_load_i(carry_load_i),
        .carry_value_i(carry_value_i), .done_o(done_o), .executed_o(executed_o),
        .result_wr_o(result_wr_o), .result_o(result_o), .carry_flag_o(carry_flag_o),
        .fault_flag_o(fault_flag_o), .zero_flag_o(zero_flag_o));

    task automatic report_and_stop;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic issue(input bmsu_row_type r);
        @(posedge core_clk_i);
        go <= 1'b1;
        cmd <= r;
        @(posedge core_clk_i);
        go <= 1'b0;
    endtask

    task automatic do_op(input bmsu_row_type r);
        logic [63:0] m;
        int n;
        m = {{16{r.wr[3]}}, {16{r.wr[2]}}, {16{r.wr[1]}}, {16{r.wr[0]}}};
        n = 0;
        issue(r);
        while (done_o !== 1'b1 && n < 200) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 200) begin
            error_cnt++;
            report_and_stop();
        end else begin
            chk(executed_o, r.cond);
            chk({carry_flag_o, fault_flag_o, zero_flag_o}, r.flg);
            if (r.cond && !r.flg[1]) begin
                chk(result_o & m, r.res);
                chk(result_wr_o, r.wr);
            end
        end
    endtask

    initial begin
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        foreach (rows[i]) begin
            do_op(rows[i]);
        end
        // direct carry load, then borrow-free subtract proves it landed
        @(posedge core_clk_i);
        carry_load_i <= 1'b1;
        @(posedge core_clk_i);
        carry_load_i <= 1'b0;
        do_op('{op_dsub, 1'b1, 32'h5, 32'h3, 17'h0, 64'h2, 4'h3, 3'h0});
        // reset in the middle of a long divide must abandon it cleanly
        issue(rows[6]);
        repeat (20) @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (8) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk({ready_o, done_o, carry_flag_o, fault_flag_o, zero_flag_o}, 64'h10);
        chk(result_o, 64'h0);
        @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        do_op(rows[3]);
        report_and_stop();
    end
endmodule
